// >>> design/fspc_pkg.sv
/*
  Constants for the flash self-program control block.
  Assumes a 26-bit byte address space and a flash built of equal blocks.
*/
`default_nettype none
package fspc_pkg;
  localparam int ADDR_W = 26;
  localparam int BLK_SHIFT = 15;
  localparam logic [2:0] BOOT_AREA_BIT = 3'h4;
  localparam logic [ADDR_W-1:0] RAM_BASE_LARGE = 26'h3FFD800;
  localparam logic [ADDR_W-1:0] RAM_BASE_SMALL = 26'h3FFB000;
  localparam logic [ADDR_W-1:0] MASKABLE_OFS = 26'h0000004;
  localparam logic [ADDR_W-1:0] NMI_FLASH_VEC = 26'h0000010;
  localparam logic [ADDR_W-1:0] INT_FLASH_VEC = 26'h0000080;
  typedef enum logic [1:0] {FSPC_NORMAL, FSPC_EXT_PROG, FSPC_PROHIBITED} fspc_mode_t;
endpackage
`default_nettype wire

// >>> design/fspc_ctrl.sv
/*
  Flash self-program control: mode pin capture, boot swap decode,
  fetch blocking, interrupt entry redirection and write protect.
  Assumes mode pins come from pads (synchronised here) and all core
  signals are on core_clk.
*/
// Contract
// - In external programming mode every pin not used for programming holds its reset state.
// - Boot swap exchanges blocks 0 to 3 with blocks 4 to 7.
// - No instruction fetch from flash is allowed while self-programming runs.
// - An NMI in self-programming status enters at the internal RAM start address.
// - A maskable interrupt in self-programming status enters at RAM start plus four.
// - The primary mode pin is sampled at reset release and must be 0 V for normal mode.
// - Flash writes are refused unless the primary mode pin is at supply level; the code refuses them only while self_prog_active is high.
// - Primary high with secondary low selects external programming; both high is prohibited.
`default_nettype none
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter bit LARGE_RAM = 1'b1
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Mode pins from pads
  input wire logic primary_mode_pin,
  input wire logic secondary_mode_pin,
  // Software control
  input wire logic self_prog_active,
  input wire logic swap_set,
  input wire logic swap_value,
  // Flash access from the core
  input wire logic flash_req,
  input wire logic flash_write,
  input wire logic flash_fetch,
  input wire logic [fspc_pkg::ADDR_W-1:0] flash_addr,
  // Interrupt entry requests
  input wire logic nmi_take,
  input wire logic int_take,
  // Outputs
  output logic flash_go,
  output logic flash_we,
  output logic [fspc_pkg::ADDR_W-1:0] flash_phys_addr,
  output logic fetch_blocked,
  output logic write_refused,
  output logic vec_valid,
  output logic [fspc_pkg::ADDR_W-1:0] vec_addr,
  output fspc_pkg::fspc_mode_t op_mode,
  output logic pins_hold_reset,
  output logic swap_state
);
  import fspc_pkg::*;

  logic [1:0] prim_sync, sec_sync;
  logic captured;
  logic next_captured;
  fspc_mode_t next_op_mode;
  logic next_pins_hold_reset, next_swap_state;
  logic next_flash_go, next_flash_we, next_fetch_blocked, next_write_refused;
  logic next_vec_valid;
  logic [ADDR_W-1:0] next_flash_phys_addr, next_vec_addr, ram_base;
  logic [ADDR_W-1:0] ram_int_entry;

  // Swap remap: flipping the top block-index bit exchanges the two boot areas
  function automatic logic [ADDR_W-1:0] swap_map(input logic [ADDR_W-1:0] a, input logic s);
    logic [ADDR_W-1:0] r;
    r = a;
    if (s && (a[ADDR_W-1:BLK_SHIFT+3] == '0))
    begin
      r[BLK_SHIFT+2:BLK_SHIFT] = a[BLK_SHIFT+2:BLK_SHIFT] ^ BOOT_AREA_BIT;
    end
    return r;
  endfunction

  assign ram_base = LARGE_RAM ? RAM_BASE_LARGE : RAM_BASE_SMALL;
  // Maskable entry sits one word above the NMI entry; both bases leave room for it
  assign ram_int_entry = ADDR_W'(ram_base + MASKABLE_OFS);

  // Pad synchronisers, kept out of reset so they carry the pin levels through it;
  // a cleared stage would make the capture edge always see normal mode.
  // Only the second stage is read by logic.
  always_ff @(posedge core_clk)
  begin
    prim_sync <= {prim_sync[0], primary_mode_pin};
    sec_sync <= {sec_sync[0], secondary_mode_pin};
  end

  // Next-state logic for mode capture and flash access control
  always_comb
  begin
    next_captured = 1'b1;
    next_op_mode = op_mode;
    next_swap_state = swap_state;
    if (!captured)
    begin
      // Mode chosen once, at the first edge after release
      if (!prim_sync[1])
        next_op_mode = FSPC_NORMAL;
      else if (!sec_sync[1])
        next_op_mode = FSPC_EXT_PROG;
      else
        next_op_mode = FSPC_PROHIBITED;
    end
    // Pins freeze at reset state unless plainly in normal mode
    next_pins_hold_reset = (next_op_mode != FSPC_NORMAL);
    if (swap_set)
      next_swap_state = swap_value;
    next_fetch_blocked = flash_req && flash_fetch && self_prog_active;
    next_write_refused = flash_req && flash_write && self_prog_active && !prim_sync[1];
    next_flash_go = flash_req && !next_fetch_blocked && !next_write_refused;
    next_flash_we = next_flash_go && flash_write;
    next_flash_phys_addr = swap_map(flash_addr, swap_state);
    // NMI wins over maskable entry
    next_vec_valid = nmi_take || int_take;
    if (nmi_take)
      next_vec_addr = self_prog_active ? ram_base : NMI_FLASH_VEC;
    else if (int_take)
      next_vec_addr = self_prog_active ? ram_int_entry : INT_FLASH_VEC;
    else
      next_vec_addr = vec_addr;
  end

  // Registers; swap state resets to unswapped, software restores it
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      captured <= 1'b0;
      op_mode <= FSPC_NORMAL;
      pins_hold_reset <= 1'b1;
      swap_state <= 1'b0;
      flash_go <= 1'b0;
      flash_we <= 1'b0;
      flash_phys_addr <= '0;
      fetch_blocked <= 1'b0;
      write_refused <= 1'b0;
      vec_valid <= 1'b0;
      vec_addr <= '0;
    end
    else
    begin
      captured <= next_captured;
      op_mode <= next_op_mode;
      pins_hold_reset <= next_pins_hold_reset;
      swap_state <= next_swap_state;
      flash_go <= next_flash_go;
      flash_we <= next_flash_we;
      flash_phys_addr <= next_flash_phys_addr;
      fetch_blocked <= next_fetch_blocked;
      write_refused <= next_write_refused;
      vec_valid <= next_vec_valid;
      vec_addr <= next_vec_addr;
    end
  end

  // Request shapes that the checks start from
  sequence s_fetch_in_prog;
    flash_req && flash_fetch && self_prog_active;
  endsequence
  sequence s_write_unprotected;
    flash_req && flash_write && self_prog_active && !prim_sync[1];
  endsequence
  sequence s_write_pin_high;
    flash_req && flash_write && !flash_fetch && prim_sync[1];
  endsequence
  sequence s_nmi_in_prog;
    nmi_take && self_prog_active;
  endsequence
  sequence s_int_in_prog;
    int_take && !nmi_take && self_prog_active;
  endsequence
  sequence s_nmi_in_app;
    nmi_take && !self_prog_active;
  endsequence
  sequence s_int_in_app;
    int_take && !nmi_take && !self_prog_active;
  endsequence
  sequence s_low_area_swapped;
    swap_state && (flash_addr[ADDR_W-1:BLK_SHIFT+3] == '0);
  endsequence
  // Reset release: not yet captured, then captured one edge later
  sequence s_first_capture;
    !captured ##1 captured;
  endsequence

  // Checks
  AST_FETCH_BLOCK: assert property (@(posedge core_clk) disable iff (reset)
    s_fetch_in_prog |=> (fetch_blocked && !flash_go))
    else $error("fetch during self programming not blocked");
  AST_WP: assert property (@(posedge core_clk) disable iff (reset)
    s_write_unprotected |=> (write_refused && !flash_we))
    else $error("unprotected flash write");
  AST_WRITE_PASS: assert property (@(posedge core_clk) disable iff (reset)
    s_write_pin_high |=> (flash_go && flash_we && !write_refused))
    else $error("write refused with the pin at supply level");
  AST_NMI_VEC: assert property (@(posedge core_clk) disable iff (reset)
    s_nmi_in_prog |=> (vec_valid && vec_addr == ram_base))
    else $error("nmi not redirected to ram");
  AST_INT_VEC: assert property (@(posedge core_clk) disable iff (reset)
    s_int_in_prog |=> (vec_valid && vec_addr == ram_int_entry))
    else $error("maskable interrupt not redirected");
  AST_NMI_FLASH: assert property (@(posedge core_clk) disable iff (reset)
    s_nmi_in_app |=> (vec_valid && vec_addr == NMI_FLASH_VEC))
    else $error("nmi left the flash vector outside self programming");
  AST_INT_FLASH: assert property (@(posedge core_clk) disable iff (reset)
    s_int_in_app |=> (vec_valid && vec_addr == INT_FLASH_VEC))
    else $error("maskable interrupt left the flash vector");
  AST_SWAP: assert property (@(posedge core_clk) disable iff (reset)
    s_low_area_swapped |=> (flash_phys_addr[BLK_SHIFT+2] != $past(flash_addr[BLK_SHIFT+2])))
    else $error("boot areas not swapped");
  AST_NOSWAP: assert property (@(posedge core_clk) disable iff (reset)
    !swap_state |=> (flash_phys_addr == $past(flash_addr)))
    else $error("address changed without swap");
  AST_MODE_CAPTURE: assert property (@(posedge core_clk) disable iff (reset)
    s_first_capture |-> ((op_mode == FSPC_NORMAL) == !$past(prim_sync[1])))
    else $error("normal mode not taken from a low primary pin");
  AST_EXT_PROG: assert property (@(posedge core_clk) disable iff (reset)
    s_first_capture |-> ((op_mode == FSPC_EXT_PROG) ==
      ($past(prim_sync[1]) && !$past(sec_sync[1]))))
    else $error("external programming mode not taken from the pin pair");
  AST_MODE_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    captured |=> $stable(op_mode))
    else $error("mode changed after capture");
  AST_PINS: assert property (@(posedge core_clk) disable iff (reset)
    captured |-> (pins_hold_reset == (op_mode != FSPC_NORMAL)))
    else $error("pin hold does not follow mode");
  AST_PINS_ENTRY: assert property (@(posedge core_clk) disable iff (reset)
    s_first_capture |-> (pins_hold_reset == $past(prim_sync[1])))
    else $error("pin hold not taken with the mode");
endmodule
`default_nettype wire

// >>> test/fspc_pin_model.sv
/*
  Far-side model: software port control and the external programmer on the mode pins.
  Assumes the bench changes its requests right after a core_clk edge.
*/
`default_nettype none
module fspc_pin_model
(
  // Requests from the bench
  input wire logic sw_raise,
  input wire logic prog_attach,
  input wire logic prog_both,
  // Mode pins
  output logic primary_mode_pin,
  output logic secondary_mode_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Software raises the pin only around rewriting; the programmer holds it high
  assign primary_mode_pin = sw_raise | prog_attach | prog_both;
  // Secondary pin stays at 0 V unless the bench asks for the prohibited pair
  assign secondary_mode_pin = prog_both;
endmodule
`default_nettype wire

// >>> test/testbench.sv
/*
  Self-checking bench for the flash self-program control block.
  Assumes one-cycle answers and synchronised mode pins.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fspc_pkg::*;
  logic core_clk = 0, reset = 1, sp = 0, sset = 0, sval = 0, rq = 0, wr = 0, fe = 0;
  logic nmi = 0, irq = 0, raise = 0, attach = 0, pp, ps, go, we, fb, wrf, vv, phr, sw;
  logic both = 0;
  logic [ADDR_W-1:0] ad = '0, pa, va;
  fspc_mode_t md;
  int n_fail = 0, checked = 0;
  fspc_pin_model pins (.sw_raise(raise), .prog_attach(attach), .prog_both(both),
    .primary_mode_pin(pp), .secondary_mode_pin(ps));
  fspc_ctrl dut (.core_clk(core_clk), .reset(reset), .primary_mode_pin(pp),
    .secondary_mode_pin(ps), .self_prog_active(sp), .swap_set(sset), .swap_value(sval),
    .flash_req(rq), .flash_write(wr), .flash_fetch(fe), .flash_addr(ad), .nmi_take(nmi),
    .int_take(irq), .flash_go(go), .flash_we(we), .flash_phys_addr(pa),
    .fetch_blocked(fb), .write_refused(wrf), .vec_valid(vv), .vec_addr(va), .op_mode(md),
    .pins_hold_reset(phr), .swap_state(sw));
  // 250 MHz core clock
  initial forever #2 core_clk = ~core_clk;
  task summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One request cycle; the registered answer is looked at on the falling edge of the cycle after the request
  task pulse(input logic r, w, f, n, i, input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    {rq, wr, fe, nmi, irq, ad} <= {r, w, f, n, i, a};
    @(posedge core_clk);
    {rq, wr, fe, nmi, irq} <= 5'h00;
    @(negedge core_clk);
  endtask
  // Only the programmer's reset is applied; pins settle long before release
  task do_reset(input logic att, input logic bth);
    @(posedge core_clk);
    attach <= att;
    both <= bth;
    reset <= 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // Reset with a given pin pair and judge the mode taken at release
  task t_mode(input logic att, input logic bth, input fspc_mode_t m, input logic hold);
    do_reset(att, bth);
    chk({md, phr}, {m, hold});
  endtask
  task t_swap;
    @(posedge core_clk);
    {sset, sval} <= 2'h3;
    @(posedge core_clk);
    sset <= 1'b0;
    pulse(1, 0, 0, 0, 0, 26'h0000100);
    chk(pa, 26'h0020100);
    chk(go, 1);
    pulse(1, 0, 0, 0, 0, 26'h0028000);
    chk(pa, 26'h0008000);
    chk(sw, 1);
  endtask
  // Self programming; the bench has no timer to touch while it runs
  task t_prog;
    @(posedge core_clk);
    sp <= 1'b1;
    pulse(1, 0, 1, 0, 0, 26'h0000200);
    chk({fb, go}, 2'h2);
    pulse(1, 1, 0, 0, 0, 26'h0000300);
    chk({wrf, we}, 2'h2);
    @(posedge core_clk);
    raise <= 1'b1;
    repeat (3) @(posedge core_clk);
    pulse(1, 1, 0, 0, 0, 26'h0000300);
    chk({wrf, we, go}, 3'h3);
    @(posedge core_clk);
    raise <= 1'b0;
    pulse(0, 0, 0, 1, 1, '0);
    chk({vv, va}, {1'b1, 26'h3FFD800});
    pulse(0, 0, 0, 0, 1, '0);
    chk({vv, va}, {1'b1, 26'h3FFD804});
    @(posedge core_clk);
    sp <= 1'b0;
    pulse(0, 0, 0, 1, 0, '0);
    chk(va, 26'h0000010);
    pulse(0, 0, 0, 0, 1, '0);
    chk({vv, va}, {1'b1, 26'h0000080});
    pulse(1, 1, 0, 0, 0, 26'h0000300);
    chk({wrf, we}, 2'h1);
  endtask
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    summarize();
  end
  initial
  begin
    t_mode(1'b0, 1'b0, FSPC_NORMAL, 1'b0);
    t_swap();
    t_prog();
    t_mode(1'b1, 1'b0, FSPC_EXT_PROG, 1'b1);
    t_mode(1'b1, 1'b1, FSPC_PROHIBITED, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
